// File: pkg/sarseq_pkg.sv
// Constants for the 10-bit successive-approximation sequencer.
// Assumes one peripheral clock drives all timing; counts are in its periods.
package sarseq_pkg;

	localparam int RES_BITS = 10;
	localparam int CNT_W    = 8;

	// Mode register layout and reset value
	localparam int          MODE_START_POS = 7;
	localparam int          MODE_SPD_MSB   = 5;
	localparam int          MODE_SPD_LSB   = 3;
	localparam int          MODE_CMP_POS   = 0;
	localparam logic [7:0]  MODE_WMASK     = 8'hb9;
	localparam logic [7:0]  MODE_RESET     = 8'h00;

	// Channel register layout and reset value
	localparam logic [7:0]  CHAN_WMASK     = 8'h03;
	localparam logic [7:0]  CHAN_RESET     = 8'h00;

	// Result word: upper six bits always zero
	localparam logic [5:0]  RES_PAD        = 6'h00;
	localparam logic [RES_BITS-1:0] SAR_MSB_ONE = 10'h200;
	localparam logic [RES_BITS-1:0] SAR_CLEAR   = 10'h000;
	localparam logic [3:0]  BIT_TOP        = 4'h9;

	// Sampling / total conversion time, peripheral clock periods
	localparam logic [CNT_W-1:0] SAMP_000 = 8'h0c;   // 12
	localparam logic [CNT_W-1:0] CONV_000 = 8'h24;   // 36
	localparam logic [CNT_W-1:0] SAMP_001 = 8'h18;   // 24
	localparam logic [CNT_W-1:0] CONV_001 = 8'h30;   // 48
	localparam logic [CNT_W-1:0] SAMP_010 = 8'h30;   // 48
	localparam logic [CNT_W-1:0] CONV_010 = 8'h48;   // 72
	localparam logic [CNT_W-1:0] SAMP_011 = 8'h58;   // 88
	localparam logic [CNT_W-1:0] CONV_011 = 8'h70;   // 112
	localparam logic [CNT_W-1:0] SAMP_100 = 8'h18;   // 24
	localparam logic [CNT_W-1:0] CONV_100 = 8'h48;   // 72
	localparam logic [CNT_W-1:0] SAMP_101 = 8'h30;   // 48
	localparam logic [CNT_W-1:0] CONV_101 = 8'h60;   // 96
	localparam logic [CNT_W-1:0] SAMP_110 = 8'h60;   // 96
	localparam logic [CNT_W-1:0] CONV_110 = 8'h90;   // 144
	localparam logic [CNT_W-1:0] SAMP_111 = 8'hb0;   // 176
	localparam logic [CNT_W-1:0] CONV_111 = 8'he0;   // 224

	typedef enum logic [1:0] {
		SS_IDLE   = 2'b00,
		SS_SAMPLE = 2'b01,
		SS_TRIAL  = 2'b10,
		SS_SETTLE = 2'b11
	} sarseq_state_t;

endpackage : sarseq_pkg

// File: design/sarseq_top.sv
// Sequencer for a 10-bit successive-approximation converter.
// Assumes the comparator answers within one clock of a tap change and
// that the register write strobes are single-cycle and synchronous.
`timescale 1ns/100ps

module sarseq_top
	import sarseq_pkg::*;
(
	input  wire logic                mclk,             // peripheral clock
	input  wire logic                rstn,             // async reset, low
	input  wire logic                ce,               // clock enable
	input  wire logic                wr_mode,          // mode reg write
	input  wire logic                wr_chan,          // channel reg write
	input  wire logic [7:0]          wdata,            // write data
	input  wire logic                cmp_ge,           // input >= tap
	output logic      [7:0]          mode_rd,          // mode reg readback
	output logic      [7:0]          chan_rd,          // channel readback
	output logic      [15:0]         result_word,      // 10-bit result
	output logic      [7:0]          result_high_byte, // 8-bit result
	output logic      [RES_BITS-1:0] tap_code,         // ladder tap select
	output logic                     sample_on,        // S/H switch closed
	output logic      [1:0]          channel_sel,      // analog mux select
	output logic                     comparator_power, // comparator on
	output logic                     conversion_end_irq, // end pulse
	output logic                     busy              // converting
);

	logic                rst_s1_reg;
	logic                rst_n_reg;
	logic [7:0]          mode_reg;
	logic [7:0]          mode_next;
	logic [7:0]          chan_reg;
	logic [7:0]          chan_next;
	logic                wr_any;
	logic                start_next;
	sarseq_state_t       state_reg;
	logic [CNT_W-1:0]    cnt_reg;
	logic [3:0]          bit_reg;
	logic [RES_BITS-1:0] sar_reg;
	logic [CNT_W-1:0]    samp_last;
	logic [CNT_W-1:0]    conv_last;
	logic                done;

	function automatic logic [CNT_W-1:0] samp_cycles(input logic [2:0] s);
		case (s)
			3'b000:  samp_cycles = SAMP_000;
			3'b001:  samp_cycles = SAMP_001;
			3'b010:  samp_cycles = SAMP_010;
			3'b011:  samp_cycles = SAMP_011;
			3'b100:  samp_cycles = SAMP_100;
			3'b101:  samp_cycles = SAMP_101;
			3'b110:  samp_cycles = SAMP_110;
			default: samp_cycles = SAMP_111;
		endcase
	endfunction : samp_cycles

	function automatic logic [CNT_W-1:0] conv_cycles(input logic [2:0] s);
		case (s)
			3'b000:  conv_cycles = CONV_000;
			3'b001:  conv_cycles = CONV_001;
			3'b010:  conv_cycles = CONV_010;
			3'b011:  conv_cycles = CONV_011;
			3'b100:  conv_cycles = CONV_100;
			3'b101:  conv_cycles = CONV_101;
			3'b110:  conv_cycles = CONV_110;
			default: conv_cycles = CONV_111;
		endcase
	endfunction : conv_cycles

	// Reset release through two flops
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_reg <= 1'b0;
			rst_n_reg  <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_reg  <= rst_s1_reg;
		end
	end

	assign wr_any     = wr_mode | wr_chan;
	assign mode_next  = wr_mode ? (wdata & MODE_WMASK) : mode_reg;
	assign chan_next  = wr_chan ? (wdata & CHAN_WMASK) : chan_reg;
	assign start_next = mode_next[MODE_START_POS];

	// Speed is only changed by a mode write, which restarts the sequence or, with start clear, stops it
	assign samp_last = samp_cycles(mode_reg[MODE_SPD_MSB:MODE_SPD_LSB])
		- 8'h01;
	assign conv_last = conv_cycles(mode_reg[MODE_SPD_MSB:MODE_SPD_LSB])
		- 8'h01;

	// A write in the final cycle wins over the latch
	assign done = (state_reg == SS_SETTLE) && (cnt_reg == conv_last)
		&& !wr_any;

	// Software registers
	always_ff @(posedge mclk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			mode_reg         <= MODE_RESET;
			chan_reg         <= CHAN_RESET;
			comparator_power <= 1'b0;
		end else if (ce) begin
			mode_reg         <= mode_next;
			chan_reg         <= chan_next;
			comparator_power <= start_next
				| mode_next[MODE_CMP_POS];
		end
	end

	assign mode_rd     = mode_reg;
	assign chan_rd     = chan_reg;
	assign channel_sel = chan_reg[1:0];

	// Sequence control
	always_ff @(posedge mclk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			state_reg <= SS_IDLE;
			cnt_reg   <= '0;
			bit_reg   <= '0;
			sample_on <= 1'b0;
			busy      <= 1'b0;
		end else if (ce) begin
			if (wr_any) begin
				cnt_reg <= '0;
				bit_reg <= BIT_TOP;
				if (start_next) begin
					state_reg <= SS_SAMPLE;
					sample_on <= 1'b1;
					busy      <= 1'b1;
				end else begin
					state_reg <= SS_IDLE;
					sample_on <= 1'b0;
					busy      <= 1'b0;
				end
			end else begin
				case (state_reg)
					SS_SAMPLE: begin
						cnt_reg <= cnt_reg + 8'h01;
						if (cnt_reg == samp_last) begin
							state_reg <= SS_TRIAL;
							sample_on <= 1'b0;
							bit_reg   <= BIT_TOP;
						end
					end
					SS_TRIAL: begin
						cnt_reg <= cnt_reg + 8'h01;
						if (bit_reg == 4'h0) begin
							state_reg <= SS_SETTLE;
						end else begin
							bit_reg <= bit_reg - 4'h1;
						end
					end
					SS_SETTLE: begin
						if (cnt_reg == conv_last) begin
							state_reg <= SS_SAMPLE;
							sample_on <= 1'b1;
							cnt_reg   <= '0;
						end else begin
							cnt_reg <= cnt_reg + 8'h01;
						end
					end
					SS_IDLE: begin
						sample_on <= 1'b0;
						busy      <= 1'b0;
					end
					default: begin
						state_reg <= SS_IDLE;
						sample_on <= 1'b0;
						busy      <= 1'b0;
					end
				endcase
			end
		end
	end

	// Binary search; the ladder carries the half-step offset so that
	// each code is centred on its input span
	always_ff @(posedge mclk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			sar_reg <= SAR_CLEAR;
		end else if (ce) begin
			if (wr_any) begin
				sar_reg <= SAR_CLEAR;
			end else if (state_reg == SS_SAMPLE
				&& cnt_reg == samp_last) begin
				sar_reg <= SAR_MSB_ONE;
			end else if (state_reg == SS_TRIAL) begin
				sar_reg[bit_reg] <= cmp_ge;
				if (bit_reg != 4'h0) begin
					sar_reg[bit_reg - 4'h1] <= 1'b1;
				end
			end else if (state_reg == SS_SETTLE
				&& cnt_reg == conv_last) begin
				sar_reg <= SAR_CLEAR;
			end
		end
	end

	assign tap_code = sar_reg;

	// Results: reset value is not promised to software
	always_ff @(posedge mclk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			result_word        <= '0;
			result_high_byte   <= '0;
			conversion_end_irq <= 1'b0;
		end else if (ce) begin
			conversion_end_irq <= done;
			if (done) begin
				result_word      <= {RES_PAD, sar_reg};
				result_high_byte <= sar_reg[9:2];
			end
		end
	end

endmodule : sarseq_top

// File: tb/sarseq_checker.sv
// Port checker for the converter sequencer.
// Assumes ce held high, so every write strobe is taken.
`timescale 1ns/100ps
module sarseq_checker (
	input wire logic        mclk,               // clock
	input wire logic        rstn,               // reset, low
	input wire logic        wr_mode,            // mode write
	input wire logic        wr_chan,            // chan write
	input wire logic [7:0]  wdata,              // data
	input wire logic        cmp_ge,             // comparator
	input wire logic [7:0]  mode_rd,            // mode
	input wire logic [15:0] result_word,        // word
	input wire logic [7:0]  result_high_byte,   // byte
	input wire logic [9:0]  tap_code,           // tap
	input wire logic        sample_on,          // track
	input wire logic        comparator_power,   // power
	input wire logic        conversion_end_irq, // irq
	input wire logic        busy                // busy
);
	localparam int CT [8] = '{36, 48, 72, 112, 72, 96, 144, 224};
	int   cnt;
	logic samp_q;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Any write restarts the conversion clock, as does a new sample
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt    <= 0;
			samp_q <= 1'b0;
		end else begin
			samp_q <= sample_on;
			if (wr_mode || wr_chan) cnt <= 0;
			else if (sample_on && !samp_q) cnt <= 1;
			else cnt <= cnt + 1;
		end
	end
	sequence s_trial_go;
		$fell(sample_on) && busy && !wr_mode && !wr_chan;
	endsequence
	a_conv_time: assert property (conversion_end_irq |-> cnt == CT[mode_rd[5:3]])
		else $error("irq off conversion time");
	a_first_trial: assert property (s_trial_go |-> tap_code == 10'h200 ##1
		tap_code == {$past(cmp_ge), 9'h100}) else $error("first trials wrong");
	a_write_wins: assert property ((wr_mode || wr_chan) |=> !conversion_end_irq)
		else $error("irq despite write");
	a_irq_single: assert property (conversion_end_irq |=> !conversion_end_irq)
		else $error("irq longer than a cycle");
	a_result_hold: assert property (!conversion_end_irq |->
		$stable(result_word) && $stable(result_high_byte))
		else $error("result moved without irq");
	a_word_layout: assert property (result_word[15:10] == 6'h00 &&
		result_high_byte == result_word[9:2]) else $error("result layout");
	a_stop_now: assert property (wr_mode && !wdata[7] |=> !busy && !sample_on)
		else $error("stop not immediate");
	a_start_sample: assert property (wr_mode && wdata[7] |=> busy && sample_on)
		else $error("start not sampling");
	a_power_mode: assert property (wr_mode |=> comparator_power ==
		($past(wdata[7]) | $past(wdata[0]))) else $error("power mode");
endmodule : sarseq_checker

bind sarseq_top sarseq_checker chk_u (.mclk(mclk), .rstn(rstn),
	.wr_mode(wr_mode), .wr_chan(wr_chan), .wdata(wdata), .cmp_ge(cmp_ge),
	.mode_rd(mode_rd), .result_word(result_word),
	.result_high_byte(result_high_byte), .tap_code(tap_code),
	.sample_on(sample_on), .comparator_power(comparator_power),
	.conversion_end_irq(conversion_end_irq), .busy(busy));

// File: tb/sarseq_analog.sv
// Comparator and ladder model; inputs are given as ideal codes.
// Assumes the sequencer changes tap_code only on clock edges.
`timescale 1ns/100ps
module sarseq_analog (
	input  wire logic        mclk,        // clock
	input  wire logic [39:0] ain,         // four input codes
	input  wire logic [1:0]  channel_sel, // mux select
	input  wire logic        sample_on,   // track
	input  wire logic [9:0]  tap_code,    // tap
	output logic             cmp_ge       // input >= tap
);
	logic [9:0] held;
	always_ff @(posedge mclk) if (sample_on) held <= ain[channel_sel*10 +: 10];
	// Half-step centring folded into the codes
	assign cmp_ge = held >= tap_code;
endmodule : sarseq_analog

// File: tb/sarseq_bench.sv
// Self-checking bench for the converter sequencer.
// Assumes ce tied high and inputs moved on the falling edge.
`timescale 1ns/100ps
module sarseq_bench;
	localparam int CT [8] = '{36, 48, 72, 112, 72, 96, 144, 224};
	logic        mclk = 1'b0, rstn = 1'b0, wr_mode = 1'b0, wr_chan = 1'b0;
	logic [7:0]  wdata = 8'h00, mode_rd, chan_rd, result_high_byte;
	logic [15:0] result_word;
	logic [9:0]  tap_code;
	logic [1:0]  channel_sel;
	logic        cmp_ge, sample_on, comparator_power, conversion_end_irq, busy;
	logic [39:0] ain = {10'h000, 10'h3ff, 10'h15a, 10'h2a5};
	int          err_total = 0, check_count = 0, n;
	sarseq_top dut_u (.mclk(mclk), .rstn(rstn), .ce(1'b1), .wr_mode(wr_mode),
		.wr_chan(wr_chan), .wdata(wdata), .cmp_ge(cmp_ge), .mode_rd(mode_rd),
		.chan_rd(chan_rd), .result_word(result_word),
		.result_high_byte(result_high_byte), .tap_code(tap_code),
		.sample_on(sample_on), .channel_sel(channel_sel),
		.comparator_power(comparator_power),
		.conversion_end_irq(conversion_end_irq), .busy(busy));
	sarseq_analog ana_u (.mclk(mclk), .ain(ain), .channel_sel(channel_sel),
		.sample_on(sample_on), .tap_code(tap_code), .cmp_ge(cmp_ge));
	always #50 mclk = ~mclk;
	task automatic end_of_test();
		if (err_total == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic m, input logic [7:0] d);
		wr_mode = m;
		wr_chan = !m;
		wdata = d;
		@(negedge mclk);
		wr_mode = 1'b0;
		wr_chan = 1'b0;
		@(negedge mclk);
	endtask : wr
	task automatic wait_irq(input int n0);
		n = n0;
		do begin
			@(negedge mclk);
			n++;
		end while (conversion_end_irq !== 1'b1 && n < 400);
		if (n >= 400) begin
			err_total++;
			$display("[ERR] %0t no conversion end", $time);
			end_of_test();
		end
	endtask : wait_irq
	task automatic start(input int s);
		wr(1'b0, 8'(s % 4));
		wr(1'b1, 8'(s * 8 + 1));
		repeat (10) @(negedge mclk);
		wr(1'b1, 8'(s * 8 + 8'h81));
		wait_irq(1);
		chk(16'(n), 16'(CT[s]));
	endtask : start
	task automatic t_speeds();
		for (int s = 0; s < 8; s++) begin
			start(s);
			chk(result_word, {6'h00, ain[(s % 4) * 10 +: 10]});
			chk({8'h00, result_high_byte}, {8'h00, ain[(s % 4) * 10 + 2 +: 8]});
			wait_irq(0);
			chk(16'(n), 16'(CT[s]));
			wr(1'b1, 8'h01);
			chk({14'h0, busy, comparator_power}, 16'h0001);
		end
	endtask : t_speeds
	task automatic t_chan_abort();
		start(0);
		repeat (20) @(negedge mclk);
		wr(1'b0, 8'h02);
		wait_irq(1);
		chk(16'(n), 16'(CT[0]));
		chk(result_word, {6'h00, ain[29:20]});
		// Write lands on the completion edge
		repeat (35) @(negedge mclk);
		wr_mode = 1'b1;
		wdata = 8'h81;
		@(negedge mclk);
		chk({15'h0, conversion_end_irq}, 16'h0000);
		wr_mode = 1'b0;
		wait_irq(0);
		chk(16'(n), 16'(CT[0]));
	endtask : t_chan_abort
	task automatic t_stop();
		wr(1'b1, 8'hff);
		chk({8'h00, mode_rd}, 16'h00b9);
		wr(1'b0, 8'hff);
		chk({8'h00, chan_rd}, 16'h0003);
		wr(1'b1, 8'h00);
		chk({14'h0, busy, comparator_power}, 16'h0000);
		n = 0;
		repeat (250) begin
			@(negedge mclk);
			if (conversion_end_irq !== 1'b0) n++;
		end
		chk(16'(n), 16'h0000);
	endtask : t_stop
	initial begin
		repeat (12) @(negedge mclk);
		rstn = 1'b1;
		repeat (3) @(negedge mclk);
		chk({8'h00, mode_rd}, 16'h0000);
		t_speeds();
		t_chan_abort();
		t_stop();
		end_of_test();
	end
endmodule : sarseq_bench
